// *** rtl/sbphy_pkg.sv ***
// Shared constants for the serial bus PHY register map block.
// Assumes a 40 MHz register clock and an AHB-Lite bus with 32-bit data.
package sbphy_pkg;

  // Register clock period and long bus reset duration
  localparam int unsigned CLK_PERIOD_NS   = 25;
  localparam int unsigned LONG_RST_US     = 166;
  localparam int unsigned LONG_RST_CYC    = (LONG_RST_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned LONG_RST_CNT_W  = 13;

  // Register indices (byte address is four times the index)
  localparam logic [3:0] IDX_NODE_IDENTITY_STATUS    = 4'h0;
  localparam logic [3:0] IDX_RESET_GAP_CONTROL       = 4'h1;
  localparam logic [3:0] IDX_PORT_CAPABILITY_INFO    = 4'h2;
  localparam logic [3:0] IDX_SPEED_DELAY_INFO        = 4'h3;
  localparam logic [3:0] IDX_LINK_CONTENDER_POWER    = 4'h4;
  localparam logic [3:0] IDX_INTERRUPT_FEATURE_EN    = 4'h5;
  localparam logic [3:0] IDX_LEGACY_SPEED_BRIDGE     = 4'h6;
  localparam logic [3:0] IDX_PAGE_PORT_SELECT        = 4'h7;

  // Byte address decode of the sixteen register window
  localparam logic [7:0] REG_WIN_MASK   = 8'hC0;
  localparam logic [7:0] REG_WIN_BASE   = 8'h00;
  localparam int unsigned IDX_LSB       = 2;
  localparam int unsigned PAGED_BIT     = 3;

  // Interrupt status and mask registers
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h40;
  localparam logic [7:0] ADDR_IRQ_MASK   = 8'h44;
  localparam int unsigned IRQ_W          = 4;
  localparam int unsigned IRQ_SELF_ID    = 0;
  localparam int unsigned IRQ_BUS_RESET  = 1;
  localparam int unsigned IRQ_CABLE_PWR  = 2;
  localparam int unsigned IRQ_LONG_DONE  = 3;

  // Field layouts: bit position 0 is data bit 7
  localparam int unsigned NODE_ADDR_HI   = 7;
  localparam int unsigned NODE_ADDR_LO   = 2;
  localparam int unsigned ROOT_BIT       = 1;
  localparam int unsigned CABLE_PWR_BIT  = 0;
  localparam int unsigned RHB_BIT        = 7;
  localparam int unsigned IBR_BIT        = 6;
  localparam int unsigned GAP_HI         = 5;
  localparam int unsigned GAP_LO         = 0;
  localparam int unsigned LCTRL_BIT      = 7;
  localparam int unsigned CONT_BIT       = 6;
  localparam int unsigned JITTER_HI      = 5;
  localparam int unsigned JITTER_LO      = 3;
  localparam int unsigned PWR_HI         = 2;
  localparam int unsigned PWR_LO         = 0;
  localparam int unsigned LEG_SPD_HI     = 7;
  localparam int unsigned LEG_SPD_LO     = 5;
  localparam int unsigned BLINK_BIT      = 4;
  localparam int unsigned BRIDGE_HI      = 3;
  localparam int unsigned BRIDGE_LO      = 2;
  localparam int unsigned PAGE_HI        = 7;
  localparam int unsigned PAGE_LO        = 5;
  localparam int unsigned PORT_HI        = 3;
  localparam int unsigned PORT_LO        = 0;
  localparam int unsigned EXT_HI         = 7;
  localparam int unsigned EXT_LO         = 5;
  localparam int unsigned NPORT_HI       = 3;
  localparam int unsigned NPORT_LO       = 0;
  localparam int unsigned SPEED_HI       = 7;
  localparam int unsigned SPEED_LO       = 5;
  localparam int unsigned DELAY_HI       = 3;
  localparam int unsigned DELAY_LO       = 0;

  // Fixed field values
  localparam logic [2:0] EXTENDED_VAL    = 3'h7;
  localparam logic [3:0] NUM_PORTS_VAL   = 4'h3;
  localparam logic [2:0] PHY_SPEED_VAL   = 3'h7;
  localparam logic [3:0] DELAY_VAL       = 4'h0;
  localparam logic [2:0] JITTER_VAL      = 3'h0;

  // Reset values
  localparam logic [5:0] GAP_RST         = 6'h3F;
  localparam logic       LCTRL_RST       = 1'b1;
  localparam logic [7:0] FEAT_RST        = 8'h00;
  localparam logic [2:0] PAGE_RST        = 3'h0;
  localparam logic [3:0] PORT_RST        = 4'h0;

endpackage : sbphy_pkg

// *** rtl/sbphy_regmap.sv ***
// Register map of a three-port serial bus cable PHY, reached over AHB-Lite.
// Assumes PHY core event pulses on the same clock; the cable power sense is a
// raw pin and is synchronised here.
//
// Behaviour
// - Sixteen registers, selected by a four-bit register index.
// - Indices 0-7 are fixed base registers; 8-F come from the selected page (here 8-F read as zero on every page).
// - The page used for indices 8-F is the page select field of register 7.
// - Base register contents never depend on the selected page.
// - Reserved registers and reserved fields read as zero.
// - Every register of pages 2 to 6 reads as zero.
// - Register 0 holds the read-only six-bit node address from self-identification.
// - Node address invalid after bus reset until self-id; then status transfer.
// - Root flag clears on bus reset, sets when this node becomes root.
// - Cable power flag follows the cable power sense input.
// - Root holdoff set makes the node contend for root after next reset.
// - Root holdoff clears on hardware reset, survives bus resets.
// - Long reset request starts a 166 us reset after transfers finish.
// - Gap setting returns to 3Fh on reset or two resets without write.
//
// The AHB-Lite register port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module sbphy_regmap
  import sbphy_pkg::*;
#(
  parameter int unsigned P_LONG_RST_CYC = LONG_RST_CYC, // Long reset length in cycles
  parameter logic [2:0]  P_PWR_CLASS    = 3'h0,         // Power class strap value
  parameter logic [2:0]  P_LEGACY_SPD   = 3'h0,         // Legacy speed field value
  parameter logic        P_BLINK        = 1'b0          // Beta link field value
)
(
  input  wire logic        i_ref_clk,        // Register clock, 40 MHz
  input  wire logic        i_nrst,           // Async reset, active low
  input  wire logic        i_hsel,           // AHB slave select
  input  wire logic [7:0]  i_haddr,          // AHB byte address
  input  wire logic [1:0]  i_htrans,         // AHB transfer type
  input  wire logic        i_hwrite,         // AHB write
  input  wire logic [2:0]  i_hsize,          // AHB size, word only
  input  wire logic [31:0] i_hwdata,         // AHB write data
  input  wire logic        i_hready,         // AHB bus ready
  output logic             o_hreadyout,      // AHB slave ready
  output logic [31:0]      o_hrdata,         // AHB read data
  output logic             o_hresp,          // AHB response, always OKAY
  input  wire logic        i_bus_reset,      // Bus reset seen, pulse
  input  wire logic        i_self_id_done,   // Self-id complete, pulse
  input  wire logic [5:0]  i_self_id_addr,   // Address won in self-id
  input  wire logic        i_became_root,    // Tree-id made us root, pulse
  input  wire logic        i_cable_power,    // Cable power sense pin
  input  wire logic        i_xfer_busy,      // Receive or transmit in progress
  input  wire logic        i_cfg_pkt,        // Config packet seen, pulse
  input  wire logic        i_cfg_rhb,        // Root holdoff in config packet
  input  wire logic        i_cfg_gap_vld,    // Config packet carries gap
  input  wire logic [5:0]  i_cfg_gap,        // Gap value in config packet
  output logic             o_root_holdoff,   // Contend for root after reset
  output logic [5:0]       o_gap_count,      // Arbitration gap setting
  output logic             o_long_reset,     // Drive long bus reset, level
  output logic             o_node_addr_vld,  // Node address valid
  output logic             o_status_xfer,    // Unsolicited reg 0 status, pulse
  output logic             o_contender,      // Contender bit
  output logic             o_link_ctrl,      // Link active control bit
  output logic [7:0]       o_feature_en,     // Interrupt and feature enables
  output logic [3:0]       o_port_select,    // Selected port for paged regs
  output logic             o_irq             // Interrupt, level high
);

  // AHB data phase state
  logic              dph_wr_reg;
  logic [7:0]        dph_addr_reg;
  logic              stall_reg;
  // Register fields
  logic [5:0]        node_addr_reg;
  logic              root_reg;
  logic              ibr_reg;
  logic              gap_pend_reg;
  logic [2:0]        pwr_class_reg;
  logic [1:0]        bridge_reg;
  logic [2:0]        page_reg;
  logic [IRQ_W-1:0]  irq_stat_reg;
  logic [IRQ_W-1:0]  irq_mask_reg;
  // Cable power synchroniser and long reset counter
  logic              cp_meta_reg;
  logic              cp_sync_reg;
  logic              cp_prev_reg;
  logic [LONG_RST_CNT_W-1:0] lr_cnt_reg;
  logic              addr_ok;
  logic              wr_en;
  logic [7:0]        wbyte;
  logic [3:0]        widx;
  logic              wbase;
  logic              gap_wr;
  logic              lr_done;
  logic [7:0]        rd_byte;
  logic [31:0]       rd_next;
  logic [3:0]        ridx;
  logic [IRQ_W-1:0]  irq_evt;
  // Address phase taken and write commit in the data phase
  assign addr_ok = i_hsel && i_htrans[1] && i_hready;
  assign wr_en   = dph_wr_reg && stall_reg;
  assign wbyte   = i_hwdata[7:0];
  assign widx    = dph_addr_reg[IDX_LSB +: 4];
  assign wbase   = ((dph_addr_reg & REG_WIN_MASK) == REG_WIN_BASE) && !widx[PAGED_BIT];
  assign gap_wr  = (wr_en && wbase && (widx == IDX_RESET_GAP_CONTROL)) ||
                   (i_cfg_pkt && i_cfg_gap_vld);
  assign lr_done = o_long_reset && (lr_cnt_reg == LONG_RST_CNT_W'(1));
  // AHB handshake: one wait state per transfer
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      dph_wr_reg   <= 1'b0;
      dph_addr_reg <= 8'h00;
      stall_reg    <= 1'b0;
      o_hreadyout  <= 1'b1;
      o_hresp      <= 1'b0;
    end
    else if (addr_ok)
    begin
      dph_wr_reg   <= i_hwrite;
      dph_addr_reg <= i_haddr;
      stall_reg    <= 1'b1;
      o_hreadyout  <= 1'b0;
    end
    else if (stall_reg)
    begin
      stall_reg    <= 1'b0;
      o_hreadyout  <= 1'b1;
    end
  end
  // Read mux of the sixteen register window
  always_comb
  begin
    ridx    = dph_addr_reg[IDX_LSB +: 4];
    rd_byte = 8'h00;
    rd_next = 32'h0000_0000;
    if ((dph_addr_reg & REG_WIN_MASK) == REG_WIN_BASE)
    begin
      if (!ridx[PAGED_BIT])
      begin
        unique case (ridx[2:0])
          IDX_NODE_IDENTITY_STATUS[2:0]:
          begin
            rd_byte[NODE_ADDR_HI:NODE_ADDR_LO] = node_addr_reg;
            rd_byte[ROOT_BIT]                  = root_reg;
            rd_byte[CABLE_PWR_BIT]             = cp_sync_reg;
          end
          IDX_RESET_GAP_CONTROL[2:0]:
          begin
            rd_byte[RHB_BIT]       = o_root_holdoff;
            rd_byte[IBR_BIT]       = ibr_reg;
            rd_byte[GAP_HI:GAP_LO] = o_gap_count;
          end
          IDX_PORT_CAPABILITY_INFO[2:0]:
          begin
            rd_byte[EXT_HI:EXT_LO]     = EXTENDED_VAL;
            rd_byte[NPORT_HI:NPORT_LO] = NUM_PORTS_VAL;
          end
          IDX_SPEED_DELAY_INFO[2:0]:
          begin
            rd_byte[SPEED_HI:SPEED_LO] = PHY_SPEED_VAL;
            rd_byte[DELAY_HI:DELAY_LO] = DELAY_VAL;
          end
          IDX_LINK_CONTENDER_POWER[2:0]:
          begin
            rd_byte[LCTRL_BIT]           = o_link_ctrl;
            rd_byte[CONT_BIT]            = o_contender;
            rd_byte[JITTER_HI:JITTER_LO] = JITTER_VAL;
            rd_byte[PWR_HI:PWR_LO]       = pwr_class_reg;
          end
          IDX_INTERRUPT_FEATURE_EN[2:0]:
            rd_byte = o_feature_en;
          IDX_LEGACY_SPEED_BRIDGE[2:0]:
          begin
            rd_byte[LEG_SPD_HI:LEG_SPD_LO] = P_LEGACY_SPD;
            rd_byte[BLINK_BIT]             = P_BLINK;
            rd_byte[BRIDGE_HI:BRIDGE_LO]   = bridge_reg;
          end
          IDX_PAGE_PORT_SELECT[2:0]:
          begin
            rd_byte[PAGE_HI:PAGE_LO] = page_reg;
            rd_byte[PORT_HI:PORT_LO] = o_port_select;
          end
        endcase
      end
      rd_next = {24'h00_0000, rd_byte};
    end
    else if (dph_addr_reg == ADDR_IRQ_STATUS)
      rd_next = {{(32-IRQ_W){1'b0}}, irq_stat_reg};
    else if (dph_addr_reg == ADDR_IRQ_MASK)
      rd_next = {{(32-IRQ_W){1'b0}}, irq_mask_reg};
  end
  // Read data loaded in the wait cycle
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      o_hrdata <= 32'h0000_0000;
    else if (!dph_wr_reg && stall_reg)
      o_hrdata <= rd_next;
  end
  // Cable power two-stage synchroniser
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      cp_meta_reg <= 1'b0;
      cp_sync_reg <= 1'b0;
      cp_prev_reg <= 1'b0;
    end
    else
    begin
      cp_meta_reg <= i_cable_power;
      cp_sync_reg <= cp_meta_reg;
      cp_prev_reg <= cp_sync_reg;
    end
  end

  // Node address, validity and status transfer
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      node_addr_reg   <= 6'h00;
      o_node_addr_vld <= 1'b0;
      o_status_xfer   <= 1'b0;
    end
    else
    begin
      o_status_xfer <= i_self_id_done;
      if (i_self_id_done)
      begin
        node_addr_reg   <= i_self_id_addr;
        o_node_addr_vld <= 1'b1;
      end
      else if (i_bus_reset || lr_done)
        o_node_addr_vld <= 1'b0;
    end
  end

  // Root flag
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      root_reg <= 1'b0;
    // set by tree-id, cleared by bus reset
    else if (i_became_root)
      root_reg <= 1'b1;
    else if (i_bus_reset || lr_done)
      root_reg <= 1'b0;
  end

  // Root holdoff: no bus reset term
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      o_root_holdoff <= 1'b0;
    else if (i_cfg_pkt)
      o_root_holdoff <= i_cfg_rhb;
    else if (wr_en && wbase && (widx == IDX_RESET_GAP_CONTROL))
      o_root_holdoff <= wbyte[RHB_BIT];
  end

  // Gap setting and two-reset fallback
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_gap_count  <= GAP_RST;
      gap_pend_reg <= 1'b0;
    end
    else if (gap_wr)
    begin
      o_gap_count  <= (i_cfg_pkt && i_cfg_gap_vld) ? i_cfg_gap : wbyte[GAP_HI:GAP_LO];
      gap_pend_reg <= 1'b0;
    end
    else if (i_bus_reset || lr_done)
    begin
      if (gap_pend_reg)
        o_gap_count <= GAP_RST;
      gap_pend_reg <= 1'b1;
    end
  end

  // Long reset request and drive timer
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      ibr_reg      <= 1'b0;
      o_long_reset <= 1'b0;
      lr_cnt_reg   <= '0;
    end
    else
    begin
      // wait for idle, then 166 us
      if (o_long_reset)
      begin
        lr_cnt_reg <= lr_cnt_reg - LONG_RST_CNT_W'(1);
        if (lr_done)
          o_long_reset <= 1'b0;
      end
      else if (ibr_reg && !i_xfer_busy)
      begin
        o_long_reset <= 1'b1;
        lr_cnt_reg   <= LONG_RST_CNT_W'(P_LONG_RST_CYC);
      end
      if (i_bus_reset || lr_done)
        ibr_reg <= 1'b0;
      else if (wr_en && wbase && (widx == IDX_RESET_GAP_CONTROL) && !o_long_reset)
        ibr_reg <= wbyte[IBR_BIT];
    end
  end

  // Writable base fields
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_link_ctrl   <= LCTRL_RST;
      o_contender   <= 1'b0;
      pwr_class_reg <= P_PWR_CLASS;
      o_feature_en  <= FEAT_RST;
      bridge_reg    <= 2'h0;
      page_reg      <= PAGE_RST;
      o_port_select <= PORT_RST;
    end
    // read-only fields have no write path
    else if (wr_en && wbase)
    begin
      // position 0 is data bit 7
      unique case (widx[2:0])
        IDX_LINK_CONTENDER_POWER[2:0]:
        begin
          o_link_ctrl   <= wbyte[LCTRL_BIT];
          o_contender   <= wbyte[CONT_BIT];
          pwr_class_reg <= wbyte[PWR_HI:PWR_LO];
        end
        IDX_INTERRUPT_FEATURE_EN[2:0]:
          o_feature_en <= wbyte;
        IDX_LEGACY_SPEED_BRIDGE[2:0]:
          bridge_reg <= wbyte[BRIDGE_HI:BRIDGE_LO];
        IDX_PAGE_PORT_SELECT[2:0]:
        begin
          page_reg      <= wbyte[PAGE_HI:PAGE_LO];
          o_port_select <= wbyte[PORT_HI:PORT_LO];
        end
        default:
          page_reg <= page_reg;
      endcase
    end
  end

  // Interrupt events
  always_comb
  begin
    irq_evt                = '0;
    irq_evt[IRQ_SELF_ID]   = i_self_id_done;
    irq_evt[IRQ_BUS_RESET] = i_bus_reset;
    irq_evt[IRQ_CABLE_PWR] = cp_sync_reg ^ cp_prev_reg;
    irq_evt[IRQ_LONG_DONE] = lr_done;
  end

  // Sticky status, write one to clear, set wins
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      irq_stat_reg <= '0;
      irq_mask_reg <= '0;
      o_irq        <= 1'b0;
    end
    else
    begin
      if (wr_en && (dph_addr_reg == ADDR_IRQ_STATUS))
        irq_stat_reg <= (irq_stat_reg & ~i_hwdata[IRQ_W-1:0]) | irq_evt;
      else
        irq_stat_reg <= irq_stat_reg | irq_evt;
      if (wr_en && (dph_addr_reg == ADDR_IRQ_MASK))
        irq_mask_reg <= i_hwdata[IRQ_W-1:0];
      o_irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end

endmodule : sbphy_regmap

`default_nettype wire

// *** dv/sbphy_regmap_checker.sv ***
// Concurrent checks on the serial bus PHY register map ports.
// Assumes one clock domain and a bind from the bench top.
`timescale 1ns/100ps
`default_nettype none
module sbphy_regmap_checker #(
  parameter int unsigned P_LONG_RST_CYC = 6640 // Long reset length
)
(
  input wire logic       i_ref_clk,       // Clock
  input wire logic       i_nrst,          // Reset, active low
  input wire logic       i_hsel,          // Select
  input wire logic [1:0] i_htrans,        // Transfer type
  input wire logic       i_hready,        // Bus ready
  input wire logic       o_hreadyout,     // Slave ready
  input wire logic       i_bus_reset,     // Bus reset pulse
  input wire logic       i_self_id_done,  // Self-id pulse
  input wire logic       i_xfer_busy,     // Transfer busy
  input wire logic       i_cfg_pkt,       // Config packet
  input wire logic       i_cfg_rhb,       // Holdoff in packet
  input wire logic       i_cfg_gap_vld,   // Gap in packet
  input wire logic [5:0] i_cfg_gap,       // Gap value
  input wire logic       o_root_holdoff,  // Holdoff flag
  input wire logic [5:0] o_gap_count,     // Gap setting
  input wire logic       o_long_reset,    // Long reset level
  input wire logic       o_node_addr_vld, // Address valid
  input wire logic       o_status_xfer    // Status transfer
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);
  logic [15:0] lr_len;
  // Length of the running long reset
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      lr_len <= 16'h0;
    else if (o_long_reset)
      lr_len <= lr_len + 16'h1;
    else
      lr_len <= 16'h0;
  end
  property p_hready; i_hsel && i_htrans[1] && i_hready |=> !o_hreadyout ##1 o_hreadyout;
  endproperty
  a_hready: assert property (p_hready) else $error("wait state not one cycle");
  property p_status; 1'b1 |=> o_status_xfer == $past(i_self_id_done); endproperty
  a_status: assert property (p_status) else $error("status transfer misplaced");
  property p_addr_vld; i_self_id_done |=> o_node_addr_vld; endproperty
  a_addr_vld: assert property (p_addr_vld) else $error("address not valid");
  property p_bus_clr; i_bus_reset && !i_self_id_done |=> !o_node_addr_vld; endproperty
  a_bus_clr: assert property (p_bus_clr) else $error("address valid kept");
  property p_cfg_rhb; i_cfg_pkt |=> o_root_holdoff == $past(i_cfg_rhb); endproperty
  a_cfg_rhb: assert property (p_cfg_rhb) else $error("holdoff not from packet");
  property p_rhb_keep; i_bus_reset && !i_cfg_pkt && o_hreadyout |=> $stable(o_root_holdoff);
  endproperty
  a_rhb_keep: assert property (p_rhb_keep) else $error("holdoff lost on reset");
  property p_cfg_gap;
    i_cfg_pkt && i_cfg_gap_vld && !i_bus_reset && !o_long_reset |=>
      o_gap_count == $past(i_cfg_gap);
  endproperty
  a_cfg_gap: assert property (p_cfg_gap) else $error("gap not from packet");
  property p_long_wait; $rose(o_long_reset) |-> !$past(i_xfer_busy); endproperty
  a_long_wait: assert property (p_long_wait) else $error("long reset during busy");
  property p_long_len; $fell(o_long_reset) |-> lr_len == P_LONG_RST_CYC; endproperty
  a_long_len: assert property (p_long_len) else $error("long reset length wrong");
endmodule : sbphy_regmap_checker
`default_nettype wire

// *** dv/sbphy_core_model.sv ***
// Behavioural PHY core that raises bus events on command.
// Assumes commands arrive one at a time, off the clock edge.
`timescale 1ns/100ps
`default_nettype none
module sbphy_core_model (
  input  wire logic       i_ref_clk,      // Clock
  input  wire logic       i_nrst,         // Reset, active low
  input  wire logic       i_go,           // Command strobe
  input  wire logic [2:0] i_cmd,          // Event kind
  input  wire logic [5:0] i_arg,          // Event value
  output logic            o_bus_reset,    // Bus reset pulse
  output logic            o_self_id_done, // Self-id pulse
  output logic [5:0]      o_self_id_addr, // Won address
  output logic            o_became_root,  // Root pulse
  output logic            o_cfg_pkt,      // Config packet pulse
  output logic            o_cfg_rhb,      // Holdoff in packet
  output logic            o_cfg_gap_vld,  // Gap in packet
  output logic [5:0]      o_cfg_gap       // Gap value
);
  // One cycle pulses; value lines scramble when not qualified
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_bus_reset    <= 1'b0;
      o_self_id_done <= 1'b0;
      o_self_id_addr <= 6'h0;
      o_became_root  <= 1'b0;
      o_cfg_pkt      <= 1'b0;
      o_cfg_rhb      <= 1'b0;
      o_cfg_gap_vld  <= 1'b0;
      o_cfg_gap      <= 6'h0;
    end
    else
    begin
      o_bus_reset    <= i_go && (i_cmd == 3'h1);
      o_self_id_done <= i_go && (i_cmd == 3'h2);
      o_self_id_addr <= (i_go && i_cmd == 3'h2) ? i_arg : ~o_self_id_addr;
      o_became_root  <= i_go && (i_cmd == 3'h3);
      o_cfg_pkt      <= i_go && (i_cmd[2:1] == 2'h2);
      o_cfg_rhb      <= i_go && (i_cmd == 3'h4);
      o_cfg_gap_vld  <= i_go && (i_cmd == 3'h4);
      o_cfg_gap      <= (i_go && i_cmd == 3'h4) ? i_arg : ~o_cfg_gap;
    end
  end
endmodule : sbphy_core_model
`default_nettype wire

// *** dv/sbphy_regmap_tb_top.sv ***
// Self-checking bench: AHB-Lite master tasks and PHY core event model.
// Assumes the design answers each transfer with one wait state.
`timescale 1ns/100ps
`default_nettype none
module sbphy_regmap_tb_top;
  localparam int unsigned   LR = 20;
  localparam logic [63:0]   RV = 64'h0000_0080_E0E3_3F01; // Base reset image
  logic        clk, nrst, hsel, hwrite, hready, hrdy, hresp, busy, cpwr, go;
  logic        bres, sid, root, cfg, crhb, cgv, root_holdoff_flag, lres, avld, sx, cont, lct, irq;
  logic [1:0]  htrans;
  logic [2:0]  cmd, hsize;
  logic [3:0]  psel;
  logic [5:0]  arg, said, gapi, gap;
  logic [7:0]  haddr, fen;
  logic [31:0] hwdata, hrdata, q;
  int          fails, check_count, n;
  // Clock and bus ready loop
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  assign hready = hrdy;
  assign hsize = 3'h2;
  sbphy_regmap #(.P_LONG_RST_CYC(LR)) u_dut (.i_ref_clk(clk), .i_nrst(nrst), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
    .i_hwdata(hwdata), .i_hready(hready), .o_hreadyout(hrdy), .o_hrdata(hrdata),
    .o_hresp(hresp), .i_bus_reset(bres), .i_self_id_done(sid), .i_self_id_addr(said),
    .i_became_root(root), .i_cable_power(cpwr), .i_xfer_busy(busy), .i_cfg_pkt(cfg),
    .i_cfg_rhb(crhb), .i_cfg_gap_vld(cgv), .i_cfg_gap(gapi), .o_root_holdoff(root_holdoff_flag),
    .o_gap_count(gap), .o_long_reset(lres), .o_node_addr_vld(avld), .o_status_xfer(sx),
    .o_contender(cont), .o_link_ctrl(lct), .o_feature_en(fen), .o_port_select(psel),
    .o_irq(irq));
  sbphy_core_model u_core (.i_ref_clk(clk), .i_nrst(nrst), .i_go(go), .i_cmd(cmd),
    .i_arg(arg), .o_bus_reset(bres), .o_self_id_done(sid), .o_self_id_addr(said),
    .o_became_root(root), .o_cfg_pkt(cfg), .o_cfg_rhb(crhb), .o_cfg_gap_vld(cgv),
    .o_cfg_gap(gapi));
  task automatic conclude();
    if (fails == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : conclude
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e)
    begin
      fails++;
      $display("mismatch %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    k = 0;
    do begin @(posedge clk); k++; end while (hready !== 1'b1 && k < 50);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin @(posedge clk); k++; end while (hready !== 1'b1 && k < 100);
    q = hrdata;
    if (k >= 100)
    begin
      fails++;
      conclude();
    end
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, {24'h0, d});
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [7:0] e, input string nm);
    xfer(1'b0, a, 32'h0);
    chk(nm, q, {24'h0, e});
  endtask : rc
  task automatic ev(input logic [2:0] c, input logic [5:0] v);
    cmd <= c;
    arg <= v;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : ev
  task automatic rst();
    nrst <= 1'b0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
  endtask : rst
  // Hang guard
  initial
  begin
    repeat (60000) @(posedge clk);
    fails++;
    conclude();
  end
  // Main sequence
  initial
  begin
    nrst = 1'b0; hsel = 1'b0; htrans = 2'h0; hwrite = 1'b0; haddr = 8'h0; hwdata = 32'h0;
    busy = 1'b0; cpwr = 1'b1; go = 1'b0; cmd = 3'h0; arg = 6'h0; fails = 0; check_count = 0;
    @(posedge clk);
    rst();
    chk("gap_out", {26'h0, gap}, 32'h3F);
    for (int i = 0; i < 8; i++) rc({i[5:0], 2'b00}, RV[i*8+:8], "base_reset");
    for (int i = 0; i < 4; i++)
    begin
      if (i != 1) wr({i[5:0], 2'b00}, 8'hFF);
      if (i != 1) rc({i[5:0], 2'b00}, RV[i*8+:8], "ro_write");
    end
    for (int p = 0; p < 8; p++)
    begin
      wr(8'h1C, {p[2:0], 5'h05});
      rc(8'h1C, {p[2:0], 5'h05}, "page_sel");
      for (int r = 8; r < 16; r++) wr({r[5:0], 2'b00}, 8'hFF);
      for (int r = 8; r < 16; r++) rc({r[5:0], 2'b00}, 8'h00, "paged");
      rc(8'h08, 8'hE3, "base_on_page");
    end
    chk("port_sel", {27'h0, hresp, psel}, 32'h5);
    wr(8'h1C, 8'h00);
    wr(8'h10, 8'hF8);
    rc(8'h10, 8'hC0, "reg4_fields");
    wr(8'h18, 8'hFF);
    rc(8'h18, 8'h0C, "reg6_fields");
    wr(8'h14, 8'hA5);
    chk("feature_en", {24'h0, fen}, 32'hA5);
    wr(8'h80, 8'hFF);
    rc(8'h80, 8'h00, "unmapped");
    wr(8'h44, 8'h00);
    wr(8'h40, 8'h0F);
    ev(3'h1, 6'h0);
    rc(8'h40, 8'h02, "irq_status");
    chk("irq_masked", {31'h0, irq}, 32'h0);
    wr(8'h44, 8'h02);
    repeat (2) @(posedge clk);
    chk("irq_on", {31'h0, irq}, 32'h1);
    wr(8'h40, 8'h02);
    repeat (2) @(posedge clk);
    chk("irq_off", {31'h0, irq}, 32'h0);
    rc(8'h40, 8'h00, "irq_clear");
    ev(3'h2, 6'h2A);
    rc(8'h00, 8'hA9, "node_addr");
    ev(3'h3, 6'h0);
    rc(8'h00, 8'hAB, "root_set");
    ev(3'h1, 6'h0);
    xfer(1'b0, 8'h00, 32'h0);
    chk("root_clr", {30'h0, q[1:0]}, 32'h1);
    chk("addr_vld", {31'h0, avld}, 32'h0);
    cpwr <= 1'b0;
    repeat (5) @(posedge clk);
    xfer(1'b0, 8'h00, 32'h0);
    chk("cable_pwr", {31'h0, q[0]}, 32'h0);
    cpwr <= 1'b1;
    ev(3'h4, 6'h15);
    rc(8'h04, 8'h95, "cfg_packet");
    ev(3'h1, 6'h0);
    rc(8'h04, 8'h95, "one_reset");
    ev(3'h1, 6'h0);
    rc(8'h04, 8'hBF, "two_resets");
    ev(3'h5, 6'h0);
    rc(8'h04, 8'h3F, "rhb_clr");
    ev(3'h4, 6'h15);
    rst();
    rc(8'h04, 8'h3F, "hw_reset");
    busy <= 1'b1;
    wr(8'h04, 8'h50);
    repeat (10) @(posedge clk);
    chk("long_wait", {31'h0, lres}, 32'h0);
    busy <= 1'b0;
    n = 0;
    while (lres !== 1'b1 && n < 20) begin @(posedge clk); n++; end
    n = 0;
    while (lres === 1'b1 && n < 200) begin @(posedge clk); n++; end
    chk("long_len", n, LR);
    rc(8'h04, 8'h10, "ibr_clear");
    conclude();
  end
endmodule : sbphy_regmap_tb_top
bind sbphy_regmap sbphy_regmap_checker #(.P_LONG_RST_CYC(P_LONG_RST_CYC)) u_chk (
  .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_hsel(i_hsel), .i_htrans(i_htrans),
  .i_hready(i_hready), .o_hreadyout(o_hreadyout), .i_bus_reset(i_bus_reset),
  .i_self_id_done(i_self_id_done), .i_xfer_busy(i_xfer_busy), .i_cfg_pkt(i_cfg_pkt),
  .i_cfg_rhb(i_cfg_rhb), .i_cfg_gap_vld(i_cfg_gap_vld), .i_cfg_gap(i_cfg_gap),
  .o_root_holdoff(o_root_holdoff), .o_gap_count(o_gap_count), .o_long_reset(o_long_reset),
  .o_node_addr_vld(o_node_addr_vld), .o_status_xfer(o_status_xfer));
`default_nettype wire
